// file: irf_consts.svh
`ifndef IRF_CONSTS_SVH
`define IRF_CONSTS_SVH

// Register byte offsets on the APB slave
`define IRF_OFS_FLAGS_TWO   8'h00
`define IRF_OFS_WAKE_FLAGS  8'h04
`define IRF_OFS_CLK_STOP    8'h08
`define IRF_OFS_MASK_TWO    8'h0c
`define IRF_OFS_MASK_WAKE   8'h10
`define IRF_OFS_CONFIG      8'h14
`define IRF_OFS_WAKE_SEL    8'h18

// Bit positions in the second flag register
`define IRF_BIT_DT          7
`define IRF_BIT_AD          6
`define IRF_BIT_EMPTY       5
`define IRF_BIT_TG          4
`define IRF_BIT_TFH         3
`define IRF_BIT_TFL         2

// Bit positions in the configuration register
`define IRF_CFG_TF16        0
`define IRF_CFG_CAP_SEL     1
`define IRF_CFG_CAP_RISE    2
`define IRF_CFG_OVF_EN      3
`define IRF_CFG_DT_EN       4

// Reset values and masks
`define IRF_RST_FLAGS       8'h00
`define IRF_RST_CLK_STOP    6'h3f
`define IRF_CLK_STOP_RSVD   2'h3
`define IRF_HOLD_TWO        8'hdf
`define IRF_HOLD_WAKE       8'hff
`define IRF_RST_MASK        8'h00
`define IRF_RST_CONFIG      5'h00
`define IRF_RST_WAKE_SEL    8'h00

`endif

// file: irf_pkg.sv
package irf_pkg;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } irf_apb_req_t;

   // APB answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } irf_apb_rsp_t;

   // Timer F counters and compare values
   typedef struct packed {
      logic [7:0] cntLow;
      logic [7:0] cntHigh;
      logic [7:0] cmpLow;
      logic [7:0] cmpHigh;
   } irf_timer_f_t;

endpackage

// file: irf_pin_edge.sv
`timescale 1ns/1ps
module irf_pin_edge
   import irf_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Pins and edge choice
   input  wire logic [WIDTH-1:0] pinIn,
   input  wire logic [WIDTH-1:0] riseSel,
   // One-cycle edge pulses
   output logic      [WIDTH-1:0] edgePulse
);

   typedef struct packed {
      logic [WIDTH-1:0] sync1;
      logic [WIDTH-1:0] sync2;
      logic [WIDTH-1:0] prev;
      logic [WIDTH-1:0] pulse;
   } irf_edge_state_t;

   irf_edge_state_t st;
   irf_edge_state_t nx;

   // Edge compare only on the second stage, never the first
   always_comb
   begin
      nx       = st;
      nx.sync1 = pinIn;
      nx.sync2 = st.sync1;
      nx.prev  = st.sync2;
      for (int i = 0; i < WIDTH; i++)
      begin
         nx.pulse[i] = riseSel[i] ? (st.sync2[i] & ~st.prev[i])
                                  : (~st.sync2[i] & st.prev[i]);
      end
   end

   // Pins idle high, so reset the chain high to avoid a false fall
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         st <= '{sync1: '1, sync2: '1, prev: '1, pulse: '0};
      else
         st <= nx;
   end

   assign edgePulse = st.pulse;

endmodule

// file: irf_flag_reg.sv
`timescale 1ns/1ps
module irf_flag_reg
   import irf_pkg::*;
#(
   parameter int               WIDTH     = 8,
   parameter logic [WIDTH-1:0] HOLD_MASK = '1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Set events and clearing write
   input  wire logic [WIDTH-1:0] setEv,
   input  wire logic             clrWrite,
   input  wire logic [WIDTH-1:0] wrData,
   // Flag contents
   output logic      [WIDTH-1:0] flags
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } irf_flag_state_t;

   irf_flag_state_t st;
   irf_flag_state_t nx;

   // zero clears, one keeps, set wins
   always_comb
   begin
      nx       = st;
      nx.flags = ((st.flags & ~(clrWrite ? ~wrData : '0)) | setEv) & HOLD_MASK;
   end

   // Flag storage
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         st <= '{flags: RESET_VAL};
      else
         st <= nx;
   end

   assign flags = st.flags;

endmodule

// file: irf_interrupt_request_flags.sv
// Summary of operation
// - Timer F high flag sets on a high-byte match in 8-bit mode or a full match in 16-bit mode.
// - Timer G flag sets on the chosen capture edge when capture is selected, or on overflow.
// - Converter flag sets when a conversion ends and the start/busy bit falls back to 0.
// - Direct transition flag sets when a sleep runs with the enable set and a transition occurs.
// - In the second flag register bits 7, 6, 4..0 take only a written 0; bit 5 holds nothing.
// - Eight wakeup flags set on a falling edge of their pin when it is selected for wakeup.
// - All wakeup flags reset to 0 and are cleared only by writing 0.
// - Timer F low flag sets when the low counter matches its compare in 8-bit mode.
`timescale 1ns/1ps
`include "irf_consts.svh"
module irf_interrupt_request_flags
   import irf_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // APB slave
   input  wire irf_apb_req_t apbReq,
   output irf_apb_rsp_t      apbRsp,
   // Timer F compare inputs
   input  wire irf_timer_f_t timerF,
   // Timer G sources
   input  wire logic         timerGCapturePin,
   input  wire logic         timerGOverflow,
   // Converter start/busy level
   input  wire logic         convStartBusy,
   // Power mode control
   input  wire logic         sleepExec,
   input  wire logic         directTransitionTaken,
   // Timer C and event counter set pulses
   input  wire logic [1:0]   auxFlagSet,
   // Wakeup pins
   input  wire logic [7:0]   wakeupPin,
   // Interrupt and clock stop outputs
   output logic              intReq,
   output logic [5:0]        moduleClockStop
);

   typedef struct packed {
      irf_apb_rsp_t rsp;
      logic [7:0]   maskTwo;
      logic [7:0]   maskWake;
      logic [5:0]   clkStop;
      logic [4:0]   cfgBits;
      logic [7:0]   wakeSel;
      logic         busyPrev;
      logic         tfLowPrev;
      logic         tfHighPrev;
      logic         irq;
   } irf_state_t;

   irf_state_t st;
   irf_state_t nx;

   logic [7:0] flagsTwo;
   logic [7:0] flagsWake;
   logic [7:0] setTwo;
   logic [7:0] setWake;
   logic [7:0] wakePulse;
   logic       capPulse;
   logic       apbAccess;
   logic       wrEn;
   logic       clrTwo;
   logic       clrWake;
   logic       lowMatch;
   logic       highMatch;

   // Address decode, shared by read and write paths
   function automatic logic isMapped(input logic [7:0] addr);
      case (addr)
         `IRF_OFS_FLAGS_TWO, `IRF_OFS_WAKE_FLAGS, `IRF_OFS_CLK_STOP,
         `IRF_OFS_MASK_TWO, `IRF_OFS_MASK_WAKE, `IRF_OFS_CONFIG,
         `IRF_OFS_WAKE_SEL: isMapped = 1'b1;
         default:           isMapped = 1'b0;
      endcase
   endfunction

   // Read data mux; reserved bits read zero, clock stop top bits read one
   function automatic logic [31:0] readMux(input logic [7:0] addr);
      case (addr)
         `IRF_OFS_FLAGS_TWO:  readMux = {24'h000000, flagsTwo};
         `IRF_OFS_WAKE_FLAGS: readMux = {24'h000000, flagsWake};
         `IRF_OFS_CLK_STOP:   readMux = {24'h000000, `IRF_CLK_STOP_RSVD, st.clkStop};
         `IRF_OFS_MASK_TWO:   readMux = {24'h000000, st.maskTwo};
         `IRF_OFS_MASK_WAKE:  readMux = {24'h000000, st.maskWake};
         `IRF_OFS_CONFIG:     readMux = {27'h0000000, st.cfgBits};
         `IRF_OFS_WAKE_SEL:   readMux = {24'h000000, st.wakeSel};
         default:             readMux = 32'h00000000;
      endcase
   endfunction

   // Pin synchronisers: capture pin edge follows config, wakeup falls only
   irf_pin_edge #(
      .WIDTH (1)
   ) u_capEdge (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pinIn     (timerGCapturePin),
      .riseSel   (st.cfgBits[`IRF_CFG_CAP_RISE]),
      .edgePulse (capPulse)
   );

   irf_pin_edge #(
      .WIDTH (8)
   ) u_wakeEdge (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pinIn     (wakeupPin),
      .riseSel   (8'h00),
      .edgePulse (wakePulse)
   );

   // Bus handshake terms; writes land on the edge that sees pready
   assign apbAccess = apbReq.psel & apbReq.penable;
   assign wrEn      = apbAccess & st.rsp.pready & apbReq.pwrite & isMapped(apbReq.paddr);
   assign clrTwo    = wrEn & (apbReq.paddr == `IRF_OFS_FLAGS_TWO);
   assign clrWake   = wrEn & (apbReq.paddr == `IRF_OFS_WAKE_FLAGS);

   // Timer F compare terms
   assign lowMatch  = timerF.cntLow == timerF.cmpLow;
   assign highMatch = st.cfgBits[`IRF_CFG_TF16]
                      ? ({timerF.cntHigh, timerF.cntLow} == {timerF.cmpHigh, timerF.cmpLow})
                      : (timerF.cntHigh == timerF.cmpHigh);

   // Set events of the second flag register
   always_comb
   begin
      setTwo = 8'h00;
      setTwo[`IRF_BIT_DT]  = sleepExec & st.cfgBits[`IRF_CFG_DT_EN] & directTransitionTaken;
      setTwo[`IRF_BIT_AD]  = st.busyPrev & ~convStartBusy;
      setTwo[`IRF_BIT_TG]  = (capPulse & st.cfgBits[`IRF_CFG_CAP_SEL])
                             | (timerGOverflow & st.cfgBits[`IRF_CFG_OVF_EN]);
      // high compare, on entry to match
      setTwo[`IRF_BIT_TFH] = highMatch & ~st.tfHighPrev;
      setTwo[`IRF_BIT_TFL] = ~st.cfgBits[`IRF_CFG_TF16] & lowMatch & ~st.tfLowPrev;
      setTwo[1:0]          = auxFlagSet;
   end

   assign setWake = wakePulse & st.wakeSel;

   // second flag register, bit 5 never holds
   irf_flag_reg #(
      .WIDTH     (8),
      .HOLD_MASK (`IRF_HOLD_TWO),
      .RESET_VAL (`IRF_RST_FLAGS)
   ) u_flagsTwo (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .setEv    (setTwo),
      .clrWrite (clrTwo),
      .wrData   (apbReq.pwdata[7:0]),
      .flags    (flagsTwo)
   );

   irf_flag_reg #(
      .WIDTH     (8),
      .HOLD_MASK (`IRF_HOLD_WAKE),
      .RESET_VAL (`IRF_RST_FLAGS)
   ) u_flagsWake (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .setEv    (setWake),
      .clrWrite (clrWake),
      .wrData   (apbReq.pwdata[7:0]),
      .flags    (flagsWake)
   );

   // Next state: bus slave, control registers, edge history, interrupt
   always_comb
   begin
      nx            = st;
      nx.busyPrev   = convStartBusy;
      nx.tfLowPrev  = lowMatch;
      nx.tfHighPrev = highMatch;
      // One wait state keeps read data and pready both registered
      nx.rsp.pready  = apbAccess & ~st.rsp.pready;
      nx.rsp.pslverr = 1'b0;
      if (apbAccess & ~st.rsp.pready)
      begin
         nx.rsp.pslverr = ~isMapped(apbReq.paddr);
         nx.rsp.prdata  = apbReq.pwrite ? 32'h00000000 : readMux(apbReq.paddr);
      end
      if (wrEn)
      begin
         case (apbReq.paddr)
            `IRF_OFS_CLK_STOP:  nx.clkStop  = apbReq.pwdata[5:0];
            `IRF_OFS_MASK_TWO:  nx.maskTwo  = apbReq.pwdata[7:0];
            `IRF_OFS_MASK_WAKE: nx.maskWake = apbReq.pwdata[7:0];
            `IRF_OFS_CONFIG:    nx.cfgBits  = apbReq.pwdata[4:0];
            `IRF_OFS_WAKE_SEL:  nx.wakeSel  = apbReq.pwdata[7:0];
            default:            nx.clkStop  = st.clkStop;
         endcase
      end
      // Level interrupt lags the flags by one cycle to stay a flop output
      nx.irq = |(flagsTwo & st.maskTwo) | |(flagsWake & st.maskWake);
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st.rsp        <= '{prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
         st.maskTwo    <= `IRF_RST_MASK;
         st.maskWake   <= `IRF_RST_MASK;
         st.clkStop    <= `IRF_RST_CLK_STOP;
         st.cfgBits    <= `IRF_RST_CONFIG;
         st.wakeSel    <= `IRF_RST_WAKE_SEL;
         st.busyPrev   <= 1'b0;
         st.tfLowPrev  <= 1'b0;
         st.tfHighPrev <= 1'b0;
         st.irq        <= 1'b0;
      end
      else
      begin
         st <= nx;
      end
   end

   // Outputs straight from the state flops
   assign apbRsp          = st.rsp;
   assign intReq          = st.irq;
   assign moduleClockStop = st.clkStop;

   // Checks on the flag and bus behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // A write to the second flag register clearing bit b
   sequence sClrTwo(int b);
      clrTwo && !apbReq.pwdata[b];
   endsequence

   // A write to the wakeup register clearing bit b
   sequence sClrWake(int b);
      clrWake && !apbReq.pwdata[b];
   endsequence

   // Low match entered in 8-bit mode
   sequence sLowHit;
      !st.cfgBits[`IRF_CFG_TF16] && lowMatch && !st.tfLowPrev;
   endsequence

   // High-byte match entered in 8-bit mode
   sequence sHighHit8;
      !st.cfgBits[`IRF_CFG_TF16] && (timerF.cntHigh == timerF.cmpHigh) && !st.tfHighPrev;
   endsequence

   AST_TFL_SET:
      assert property (sLowHit |=> flagsTwo[`IRF_BIT_TFL])
      else $error("timer F low flag not set on match");

   AST_TFL_16BIT_QUIET:
      assert property (st.cfgBits[`IRF_CFG_TF16] && $past(st.cfgBits[`IRF_CFG_TF16])
                       && !flagsTwo[`IRF_BIT_TFL] && !$past(auxFlagSet[0])
                       |=> !flagsTwo[`IRF_BIT_TFL])
      else $error("timer F low flag set in 16-bit mode");

   AST_TFH_8BIT:
      assert property (sHighHit8 |=> flagsTwo[`IRF_BIT_TFH])
      else $error("timer F high flag not set on 8-bit match");

   AST_TFH_16BIT:
      assert property (st.cfgBits[`IRF_CFG_TF16] && !st.tfHighPrev
                       && ({timerF.cntHigh, timerF.cntLow} == {timerF.cmpHigh, timerF.cmpLow})
                       |=> flagsTwo[`IRF_BIT_TFH])
      else $error("timer F high flag not set on 16-bit match");

   AST_TG_OVF:
      assert property (timerGOverflow && st.cfgBits[`IRF_CFG_OVF_EN] |=> flagsTwo[`IRF_BIT_TG])
      else $error("timer G flag not set on overflow");

   AST_TG_CAPTURE:
      assert property ($rose(timerGCapturePin) && st.cfgBits[`IRF_CFG_CAP_RISE]
                       && st.cfgBits[`IRF_CFG_CAP_SEL]
                       ##1 $stable(st.cfgBits)[*3]
                       |=> flagsTwo[`IRF_BIT_TG])
      else $error("timer G flag not set on capture edge");

   AST_TG_FALL:
      assert property ($fell(timerGCapturePin) && !st.cfgBits[`IRF_CFG_CAP_RISE]
                       && st.cfgBits[`IRF_CFG_CAP_SEL]
                       ##1 $stable(st.cfgBits)[*3]
                       |=> flagsTwo[`IRF_BIT_TG])
      else $error("timer G flag not set on falling capture edge");

   AST_CONV_DONE:
      assert property ($fell(convStartBusy) |=> flagsTwo[`IRF_BIT_AD])
      else $error("converter flag not set when busy falls");

   AST_DT_SET:
      assert property (sleepExec && directTransitionTaken && st.cfgBits[`IRF_CFG_DT_EN]
                       |=> flagsTwo[`IRF_BIT_DT])
      else $error("direct transition flag not set");

   AST_DT_NEEDS_ENABLE:
      assert property (!flagsTwo[`IRF_BIT_DT] && !st.cfgBits[`IRF_CFG_DT_EN]
                       |=> !flagsTwo[`IRF_BIT_DT])
      else $error("direct transition flag set while disabled");

   AST_DT_NEEDS_TAKEN:
      assert property (!flagsTwo[`IRF_BIT_DT] && !directTransitionTaken
                       |=> !flagsTwo[`IRF_BIT_DT])
      else $error("direct transition flag set with no transition");

   AST_WAKE_NEEDS_SEL:
      assert property (!flagsWake[4] && !st.wakeSel[4] |=> !flagsWake[4])
      else $error("unselected wakeup pin set its flag");

   AST_BIT5_EMPTY:
      assert property (!flagsTwo[`IRF_BIT_EMPTY])
      else $error("empty bit of second flag register holds a value");

   AST_TWO_CLEAR:
      assert property (sClrTwo(`IRF_BIT_TFL) && !setTwo[`IRF_BIT_TFL]
                       |=> !flagsTwo[`IRF_BIT_TFL])
      else $error("written zero did not clear timer F low flag");

   AST_WAKE_SET:
      assert property ($fell(wakeupPin[0]) && st.wakeSel[0] ##1 st.wakeSel[0][*3]
                       |=> flagsWake[0])
      else $error("wakeup flag not set on falling edge");

   AST_WAKE_CLEAR:
      assert property (sClrWake(3) && !setWake[3] |=> !flagsWake[3])
      else $error("written zero did not clear wakeup flag");

   AST_WRITE_ONE_KEEPS:
      assert property (clrWake && apbReq.pwdata[1] && flagsWake[1] |=> flagsWake[1])
      else $error("writing one disturbed a wakeup flag");

   AST_SET_WINS:
      assert property (sClrTwo(`IRF_BIT_AD) && setTwo[`IRF_BIT_AD] |=> flagsTwo[`IRF_BIT_AD])
      else $error("set lost against a coinciding clear");

   AST_PREADY_ONE:
      assert property (apbAccess && !st.rsp.pready |=> st.rsp.pready ##1 !st.rsp.pready)
      else $error("pready not a single cycle after one wait state");

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`include "irf_consts.svh"
module tb_top
   import irf_pkg::*;
;
   // Clock, reset and design ports
   logic         clk;
   logic         sys_rst;
   irf_apb_req_t apbReq;
   irf_apb_rsp_t apbRsp;
   irf_timer_f_t timerF;
   logic         capPin;
   logic         ovf;
   logic         convBusy;
   logic         sleepExec;
   logic         dtTaken;
   logic [1:0]   auxSet;
   logic [7:0]   wakePins;
   logic         intReq;
   logic [5:0]   clkStop;
   // Bench bookkeeping
   int           err_total;
   int           num_checks;
   logic [31:0]  rdData;
   logic         rdErr;

   irf_interrupt_request_flags i_dut
   (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .apbReq                (apbReq),
      .apbRsp                (apbRsp),
      .timerF                (timerF),
      .timerGCapturePin      (capPin),
      .timerGOverflow        (ovf),
      .convStartBusy         (convBusy),
      .sleepExec             (sleepExec),
      .directTransitionTaken (dtTaken),
      .auxFlagSet            (auxSet),
      .wakeupPin             (wakePins),
      .intReq                (intReq),
      .moduleClockStop       (clkStop)
   );

   // Free-running 4 ns clock
   initial clk = 1'b0;
   always #2 clk = ~clk;

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One APB transfer; waits on pready, the watchdog ends a dead slave
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (apbRsp.pready !== 1'b1);
      rdData = apbRsp.prdata;
      rdErr  = apbRsp.pslverr;
      apbReq.psel    <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdData, exp);
   endtask

   // Let edges pass, then look where outputs are settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Sleep instruction with or without a transition actually made
   task automatic sleepPulse(input logic taken);
      @(posedge clk);
      sleepExec <= 1'b1;
      dtTaken   <= taken;
      @(posedge clk);
      sleepExec <= 1'b0;
      dtTaken   <= 1'b0;
   endtask

   // Hang guard, well beyond the length of the sequence
   initial
   begin
      #200000;
      err_total++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      err_total  = 0;
      num_checks = 0;
      sys_rst    = 1'b1;
      apbReq     = '0;
      timerF     = '{cntLow: 8'h00, cntHigh: 8'h00, cmpLow: 8'h10, cmpHigh: 8'h21};
      capPin     = 1'b1;
      ovf        = 1'b0;
      convBusy   = 1'b0;
      sleepExec  = 1'b0;
      dtTaken    = 1'b0;
      auxSet     = 2'h0;
      wakePins   = 8'hff;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      settle(1);
      chk({31'h0, intReq}, 32'h0);
      chk({26'h0, clkStop}, 32'h3f);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h0);
      rdChk(`IRF_OFS_WAKE_FLAGS, 32'h0);
      rdChk(`IRF_OFS_CLK_STOP, 32'hff);
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, rdErr}, 32'h1);
      chk(rdData, 32'h0);
      wr(`IRF_OFS_CLK_STOP, 32'h15);
      settle(1);
      chk({26'h0, clkStop}, 32'h15);
      rdChk(`IRF_OFS_CLK_STOP, 32'hd5);
      // Timer F in 8-bit mode: low match, then high match
      @(posedge clk);
      timerF.cntLow <= 8'h10;
      settle(2);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h04);
      wr(`IRF_OFS_FLAGS_TWO, 32'h0);
      @(posedge clk);
      timerF.cntHigh <= 8'h21;
      settle(2);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h08);
      wr(`IRF_OFS_FLAGS_TWO, 32'h0);
      // 16-bit mode: a low-half match sets nothing, full match sets the high flag
      @(posedge clk);
      timerF.cntLow  <= 8'h00;
      timerF.cntHigh <= 8'h00;
      wr(`IRF_OFS_CONFIG, 32'h01);
      @(posedge clk);
      timerF.cntLow <= 8'h10;
      settle(2);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h0);
      @(posedge clk);
      timerF.cntHigh <= 8'h21;
      settle(2);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h08);
      wr(`IRF_OFS_FLAGS_TWO, 32'h0);
      // Timer G capture on falling edge, then overflow gated by its enable
      wr(`IRF_OFS_CONFIG, 32'h02);
      @(posedge clk);
      capPin <= 1'b0;
      settle(6);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h10);
      wr(`IRF_OFS_FLAGS_TWO, 32'h0);
      @(posedge clk);
      capPin <= 1'b1;
      ovf    <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      settle(6);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h0);
      wr(`IRF_OFS_CONFIG, 32'h0a);
      @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      settle(2);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h10);
      wr(`IRF_OFS_FLAGS_TWO, 32'h0);
      // Converter start then finish; only the finish sets the flag
      @(posedge clk);
      convBusy <= 1'b1;
      settle(3);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h0);
      @(posedge clk);
      convBusy <= 1'b0;
      // Sleep without enable, with enable but no transition, then both
      wr(`IRF_OFS_CONFIG, 32'h00);
      sleepPulse(1'b1);
      wr(`IRF_OFS_CONFIG, 32'h10);
      sleepPulse(1'b0);
      settle(2);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h40);
      sleepPulse(1'b1);
      settle(2);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'hc0);
      wr(`IRF_OFS_FLAGS_TWO, 32'hff);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'hc0);
      wr(`IRF_OFS_FLAGS_TWO, 32'h7f);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h40);
      // Aux flags, then a clear of both that meets a new set of bit 0
      @(posedge clk);
      auxSet <= 2'h3;
      @(posedge clk);
      auxSet <= 2'h0;
      wr(`IRF_OFS_FLAGS_TWO, 32'hbf);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h03);
      fork
         wr(`IRF_OFS_FLAGS_TWO, 32'h0);
         begin
            repeat (3) @(posedge clk);
            auxSet <= 2'h1;
            @(posedge clk);
            auxSet <= 2'h0;
         end
      join
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h01);
      wr(`IRF_OFS_FLAGS_TWO, 32'h0);
      // Wakeup pins: only selected pins flag their falling edges
      wr(`IRF_OFS_WAKE_SEL, 32'h0f);
      @(posedge clk);
      wakePins <= 8'h00;
      settle(8);
      rdChk(`IRF_OFS_WAKE_FLAGS, 32'h0f);
      @(posedge clk);
      wakePins <= 8'hff;
      wr(`IRF_OFS_WAKE_FLAGS, 32'hfe);
      rdChk(`IRF_OFS_WAKE_FLAGS, 32'h0e);
      wr(`IRF_OFS_WAKE_FLAGS, 32'hff);
      rdChk(`IRF_OFS_WAKE_FLAGS, 32'h0e);
      // Interrupt: masked, unmasked, then the flag cleared
      settle(2);
      chk({31'h0, intReq}, 32'h0);
      wr(`IRF_OFS_MASK_WAKE, 32'h02);
      settle(2);
      chk({31'h0, intReq}, 32'h1);
      wr(`IRF_OFS_WAKE_FLAGS, 32'h0);
      settle(2);
      chk({31'h0, intReq}, 32'h0);
      rdChk(`IRF_OFS_WAKE_FLAGS, 32'h0);
      rdChk(`IRF_OFS_WAKE_SEL, 32'h0f);
      // Capture on rising edge only, then the second register's interrupt
      wr(`IRF_OFS_CONFIG, 32'h06);
      @(posedge clk);
      capPin <= 1'b0;
      settle(6);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h0);
      @(posedge clk);
      capPin <= 1'b1;
      settle(6);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h10);
      rdChk(`IRF_OFS_CONFIG, 32'h06);
      wr(`IRF_OFS_MASK_TWO, 32'h10);
      rdChk(`IRF_OFS_MASK_TWO, 32'h10);
      settle(1);
      chk({31'h0, intReq}, 32'h1);
      wr(`IRF_OFS_FLAGS_TWO, 32'hef);
      settle(2);
      chk({31'h0, intReq}, 32'h0);
      rdChk(`IRF_OFS_FLAGS_TWO, 32'h0);
      stop_test();
   end
endmodule
